// *** hw/mbio_regmap.sv ***
// How it works
// [R1] Never forward polls to identities 1-10.
// [R2] Radios use identities 11 to 60; the dials here give a valid own identity from 1 to 60.
// [R3] Installer keeps system at fifty devices.
// [R4] Identity is tens dial then units dial.
// [R5] Registers 1-4 read discrete inputs 0/1.
// [R6] Registers 5-8 read current inputs, full count.
// [R7] Registers 501-502 drive discrete outputs.
// [R8] Registers 505-506 drive switched supplies.
// [R9] Only holding-register functions reach the I/O.
// [R10] Host offsets register numbers by 40000.
// [R11] I/O access only in Modbus mode.
// [R12] Answer only requests to own identity.
`timescale 1ns/1ns
module mbio_regmap (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [3:0] dial_tens,
	input wire logic [3:0] dial_units,
	input wire logic transparent_mode,
	input wire logic [3:0] discrete_input_n,
	input wire logic [3:0][15:0] current_input_n,
	input wire logic req_valid,
	input wire mbio_pkg::mbio_req_s req,
	output logic rsp_valid,
	output mbio_pkg::mbio_rsp_s rsp,
	output logic fwd_valid,
	output mbio_pkg::mbio_req_s fwd,
	output logic [7:0] own_id,
	output logic id_ok,
	output logic [1:0] discrete_output_n,
	output logic [1:0] switched_supply_n
);

	// Pins: dials, mode strap and discrete inputs pass two flops.
	localparam int PIN_W = 13;
	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;
	logic [3:0] tens_s;
	logic [3:0] units_s;
	logic modbus_mode;
	logic [3:0] di_s;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else if (ce) begin
			pin_meta <= {dial_tens, dial_units, transparent_mode, discrete_input_n};
			pin_sync <= pin_meta;
		end
	end

	assign tens_s = pin_sync[12:9];
	assign units_s = pin_sync[8:5];
	assign modbus_mode = !pin_sync[4];
	assign di_s = pin_sync[3:0];

	// Identity from the dials; settings outside 1..60 leave the slave mute.
	logic [7:0] next_own_id;
	logic next_id_ok;

	always_comb begin
		next_own_id = 8'(8'(tens_s) * mbio_pkg::TENS_WEIGHT + 8'(units_s)); // see [R4]
		next_id_ok = (tens_s <= mbio_pkg::DIAL_DIGIT_MAX) && (units_s <= mbio_pkg::DIAL_DIGIT_MAX)
			&& (next_own_id >= mbio_pkg::DIAL_ID_FIRST)
			&& (next_own_id <= mbio_pkg::DIAL_ID_LAST); // see [R4]
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			own_id <= 8'h00;
			id_ok <= 1'b0;
		end else if (ce) begin
			own_id <= next_own_id;
			id_ok <= next_id_ok;
		end
	end

	// Request decode.
	logic take;
	logic is_local;
	logic addressed;
	logic [16:0] reg_num;

	assign take = ce && req_valid;
	assign is_local = (req.slave >= mbio_pkg::LOCAL_ID_FIRST) && (req.slave <= mbio_pkg::LOCAL_ID_LAST);
	// A slave whose dials are invalid, or that runs transparent, answers nothing.
	assign addressed = modbus_mode && id_ok && (req.slave == own_id); // see [R11] see [R12]
	assign reg_num = {1'b0, req.reg_addr} + mbio_pkg::REG_NUM_BIAS;

	logic next_rsp_valid;
	mbio_pkg::mbio_rsp_s next_rsp;
	logic next_fwd_valid;
	mbio_pkg::mbio_req_s next_fwd;
	logic [1:0] next_dout;
	logic [1:0] next_supply;
	logic [7:0] exc;
	logic [15:0] rd;
	logic [1:0] idx;

	always_comb begin
		exc = 8'h00;
		rd = 16'h0000;
		idx = reg_num[1:0] - 2'h1;
		next_dout = discrete_output_n;
		next_supply = switched_supply_n;
		next_fwd_valid = take && !is_local && !addressed; // see [R1]
		next_fwd = take ? req : fwd;
		next_rsp_valid = take && addressed; // see [R12]
		next_rsp = rsp;
		if (req.func == mbio_pkg::FC_READ_HOLDING) begin
			if (reg_num >= mbio_pkg::REG_DISCRETE_INPUT_ONE
				&& reg_num <= mbio_pkg::REG_DISCRETE_INPUT_FOUR) begin
				rd = {15'h0000, di_s[idx]}; // see [R5]
			end else if (reg_num >= mbio_pkg::REG_CURRENT_INPUT_ONE
				&& reg_num <= mbio_pkg::REG_CURRENT_INPUT_FOUR) begin
				rd = current_input_n[idx]; // see [R6]
			end else if (reg_num == mbio_pkg::REG_DISCRETE_OUTPUT_ONE
				|| reg_num == mbio_pkg::REG_DISCRETE_OUTPUT_TWO) begin
				rd = {15'h0000, discrete_output_n[reg_num[0] ? 0 : 1]};
			end else if (reg_num == mbio_pkg::REG_SWITCHED_SUPPLY_THREE
				|| reg_num == mbio_pkg::REG_SWITCHED_SUPPLY_FOUR) begin
				rd = {15'h0000, switched_supply_n[reg_num[0] ? 0 : 1]};
			end else if (reg_num == mbio_pkg::REG_UNASSIGNED_OUTPUT_THREE
				|| reg_num == mbio_pkg::REG_UNASSIGNED_OUTPUT_FOUR) begin
				rd = 16'h0000;
			end else begin
				exc = mbio_pkg::EXC_ILLEGAL_ADDRESS;
			end
		end else if (req.func == mbio_pkg::FC_WRITE_SINGLE) begin
			rd = req.value;
			if (reg_num == mbio_pkg::REG_UNASSIGNED_OUTPUT_THREE
				|| reg_num == mbio_pkg::REG_UNASSIGNED_OUTPUT_FOUR) begin
				// Accepted and dropped: these slots drive nothing.
				exc = 8'h00;
			end else if (reg_num != mbio_pkg::REG_DISCRETE_OUTPUT_ONE
				&& reg_num != mbio_pkg::REG_DISCRETE_OUTPUT_TWO
				&& reg_num != mbio_pkg::REG_SWITCHED_SUPPLY_THREE
				&& reg_num != mbio_pkg::REG_SWITCHED_SUPPLY_FOUR) begin
				exc = mbio_pkg::EXC_ILLEGAL_ADDRESS;
			end else if (req.value != mbio_pkg::VALUE_OFF && req.value != mbio_pkg::VALUE_ON) begin
				exc = mbio_pkg::EXC_ILLEGAL_VALUE;
			end else if (take && addressed) begin
				if (reg_num == mbio_pkg::REG_DISCRETE_OUTPUT_ONE) begin
					next_dout[0] = req.value[0]; // see [R7]
				end else if (reg_num == mbio_pkg::REG_DISCRETE_OUTPUT_TWO) begin
					next_dout[1] = req.value[0]; // see [R7]
				end else if (reg_num == mbio_pkg::REG_SWITCHED_SUPPLY_THREE) begin
					next_supply[0] = req.value[0]; // see [R8]
				end else begin
					next_supply[1] = req.value[0]; // see [R8]
				end
			end
		end else begin
			// Coils, input registers and all else are refused.
			exc = mbio_pkg::EXC_ILLEGAL_FUNCTION; // see [R9]
		end
		if (take && addressed) begin
			next_rsp.slave = req.slave;
			next_rsp.func = (exc != 8'h00) ? (req.func | mbio_pkg::EXC_FLAG) : req.func;
			next_rsp.exc_code = exc;
			next_rsp.data = (exc != 8'h00) ? 16'h0000 : rd;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp <= '0;
			fwd_valid <= 1'b0;
			fwd <= '0;
			discrete_output_n <= mbio_pkg::OUTPUTS_RESET;
			switched_supply_n <= mbio_pkg::OUTPUTS_RESET;
		end else if (ce) begin
			rsp_valid <= next_rsp_valid;
			rsp <= next_rsp;
			fwd_valid <= next_fwd_valid;
			fwd <= next_fwd;
			discrete_output_n <= next_dout;
			switched_supply_n <= next_supply;
		end
	end

	// Checks.
	logic hit;
	assign hit = take && addressed;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	property p_local_not_forwarded;
		take && is_local |=> !fwd_valid;
	endproperty
	a_local_not_forwarded: assert property (p_local_not_forwarded) // see [R1]
		else $error("poll to a local identity was forwarded");

	property p_id_from_dials;
		ce |=> own_id == 8'($past(tens_s) * 8'h0a + $past(units_s));
	endproperty
	a_id_from_dials: assert property (p_id_from_dials) // see [R4]
		else $error("identity does not match the dials");

	property p_id_range;
		id_ok |-> own_id >= 8'h01 && own_id <= 8'h3c;
	endproperty
	a_id_range: assert property (p_id_range) // see [R4]
		else $error("identity flagged valid outside 1..60");

	property p_di_read;
		hit && req.func == 8'h03 && reg_num == 17'h00001 |=> rsp.data == {15'h0000, $past(di_s[0])};
	endproperty
	a_di_read: assert property (p_di_read) // see [R5]
		else $error("discrete input one read wrong");

	property p_ai_read;
		hit && req.func == 8'h03 && reg_num == 17'h00008 |=> rsp.data == $past(current_input_n[3]);
	endproperty
	a_ai_read: assert property (p_ai_read) // see [R6]
		else $error("current input four read wrong");

	property p_do_write;
		hit && req.func == 8'h06 && reg_num == 17'h001f6 && req.value == 16'h0001
			|=> discrete_output_n[1] && rsp.exc_code == 8'h00;
	endproperty
	a_do_write: assert property (p_do_write) // see [R7]
		else $error("discrete output two not switched on");

	property p_sp_write;
		hit && req.func == 8'h06 && reg_num == 17'h001f9 && req.value == 16'h0000
			|=> !switched_supply_n[0] && $stable(discrete_output_n);
	endproperty
	a_sp_write: assert property (p_sp_write) // see [R8]
		else $error("switched supply three not switched off");

	property p_other_func_refused;
		hit && req.func != 8'h03 && req.func != 8'h06
			|=> rsp_valid && rsp.exc_code == 8'h01 && $stable(switched_supply_n);
	endproperty
	a_other_func_refused: assert property (p_other_func_refused) // see [R9]
		else $error("non holding-register function not refused");

	property p_transparent_silent;
		take && !modbus_mode |=> !rsp_valid;
	endproperty
	a_transparent_silent: assert property (p_transparent_silent) // see [R11]
		else $error("answered while in transparent mode");

	property p_other_addr_silent;
		take && req.slave != own_id |=> !rsp_valid && $stable(discrete_output_n);
	endproperty
	a_other_addr_silent: assert property (p_other_addr_silent) // see [R12]
		else $error("answered a request for another slave");

	property p_remote_forwarded;
		take && !is_local && !addressed |=> fwd_valid && fwd == $past(req);
	endproperty
	a_remote_forwarded: assert property (p_remote_forwarded) // see [R1]
		else $error("poll to a remote identity was not forwarded");

	property p_own_not_forwarded;
		hit |=> rsp_valid && !fwd_valid;
	endproperty
	a_own_not_forwarded: assert property (p_own_not_forwarded) // see [R12]
		else $error("poll to the own identity was not answered locally");

	property p_rsp_slave;
		hit |=> rsp.slave == $past(own_id);
	endproperty
	a_rsp_slave: assert property (p_rsp_slave) // see [R12]
		else $error("answer carries a foreign slave address");

	property p_input_write_refused;
		hit && req.func == mbio_pkg::FC_WRITE_SINGLE
			&& reg_num >= mbio_pkg::REG_DISCRETE_INPUT_ONE && reg_num <= mbio_pkg::REG_CURRENT_INPUT_FOUR
			|=> rsp.exc_code == mbio_pkg::EXC_ILLEGAL_ADDRESS;
	endproperty
	a_input_write_refused: assert property (p_input_write_refused) // see [R5]
		else $error("write to an input register was accepted");

	property p_bad_value_kept;
		hit && req.func == mbio_pkg::FC_WRITE_SINGLE
			&& reg_num == mbio_pkg::REG_DISCRETE_OUTPUT_ONE && req.value > mbio_pkg::VALUE_ON
			|=> rsp.exc_code == mbio_pkg::EXC_ILLEGAL_VALUE && $stable(discrete_output_n);
	endproperty
	a_bad_value_kept: assert property (p_bad_value_kept) // see [R7]
		else $error("out of range value changed discrete output one");

	property p_supply_four_on;
		hit && req.func == mbio_pkg::FC_WRITE_SINGLE
			&& reg_num == mbio_pkg::REG_SWITCHED_SUPPLY_FOUR && req.value == mbio_pkg::VALUE_ON
			|=> switched_supply_n[1] && rsp.data == mbio_pkg::VALUE_ON;
	endproperty
	a_supply_four_on: assert property (p_supply_four_on) // see [R8]
		else $error("switched supply four not switched on");

	property p_unassigned_inert;
		hit && reg_num == mbio_pkg::REG_UNASSIGNED_OUTPUT_THREE
			|=> $stable(discrete_output_n) && $stable(switched_supply_n);
	endproperty
	a_unassigned_inert: assert property (p_unassigned_inert) // see [R8]
		else $error("unassigned output slot changed an output");

	property p_outputs_hold;
		!hit |=> $stable(discrete_output_n) && $stable(switched_supply_n);
	endproperty
	a_outputs_hold: assert property (p_outputs_hold) // see [R7]
		else $error("outputs changed without an accepted write");

	property p_ai_one_read;
		hit && req.func == mbio_pkg::FC_READ_HOLDING
			&& reg_num == mbio_pkg::REG_CURRENT_INPUT_ONE
			|=> rsp.data == $past(current_input_n[0]) && rsp.exc_code == 8'h00;
	endproperty
	a_ai_one_read: assert property (p_ai_one_read) // see [R6]
		else $error("current input one read wrong");

	property p_di_four_read;
		hit && req.func == mbio_pkg::FC_READ_HOLDING
			&& reg_num == mbio_pkg::REG_DISCRETE_INPUT_FOUR
			|=> rsp.data == {15'h0000, $past(di_s[3])};
	endproperty
	a_di_four_read: assert property (p_di_four_read) // see [R5]
		else $error("discrete input four read wrong");

endmodule

// *** hw/mbio_pkg.sv ***
package mbio_pkg;

	localparam int ID_W = 8;
	localparam int REG_W = 16;
	localparam int NUM_DI = 4;
	localparam int NUM_AI = 4;

	// Slave identity space.
	localparam logic [7:0] LOCAL_ID_FIRST = 8'h01;
	localparam logic [7:0] LOCAL_ID_LAST = 8'h0a;
	localparam logic [7:0] DIAL_ID_FIRST = 8'h01;
	localparam logic [7:0] DIAL_ID_LAST = 8'h3c;
	localparam logic [7:0] TENS_WEIGHT = 8'h0a;
	localparam logic [3:0] DIAL_DIGIT_MAX = 4'h9;

	// Function and exception codes.
	localparam logic [7:0] FC_READ_HOLDING = 8'h03;
	localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

	// Holding register numbers; the protocol address is the number minus one.
	localparam logic [16:0] REG_NUM_BIAS = 17'h00001;
	localparam logic [16:0] REG_DISCRETE_INPUT_ONE = 17'h00001;
	localparam logic [16:0] REG_DISCRETE_INPUT_FOUR = 17'h00004;
	localparam logic [16:0] REG_CURRENT_INPUT_ONE = 17'h00005;
	localparam logic [16:0] REG_CURRENT_INPUT_FOUR = 17'h00008;
	localparam logic [16:0] REG_DISCRETE_OUTPUT_ONE = 17'h001f5;
	localparam logic [16:0] REG_DISCRETE_OUTPUT_TWO = 17'h001f6;
	localparam logic [16:0] REG_UNASSIGNED_OUTPUT_THREE = 17'h001f7;
	localparam logic [16:0] REG_UNASSIGNED_OUTPUT_FOUR = 17'h001f8;
	localparam logic [16:0] REG_SWITCHED_SUPPLY_THREE = 17'h001f9;
	localparam logic [16:0] REG_SWITCHED_SUPPLY_FOUR = 17'h001fa;

	localparam logic [15:0] VALUE_OFF = 16'h0000;
	localparam logic [15:0] VALUE_ON = 16'h0001;
	localparam logic [1:0] OUTPUTS_RESET = 2'h0;

	typedef struct packed {
		logic [7:0] slave;
		logic [7:0] func;
		logic [15:0] reg_addr;
		logic [15:0] value;
	} mbio_req_s;

	typedef struct packed {
		logic [7:0] slave;
		logic [7:0] func;
		logic [7:0] exc_code;
		logic [15:0] data;
	} mbio_rsp_s;

endpackage

// *** tb/mbio_host.sv ***
`timescale 1ns/1ns
module mbio_host (
	input wire logic mclk,
	input wire logic send,
	input wire logic [7:0] slave,
	input wire logic [7:0] func,
	input wire logic [16:0] reg_num,
	input wire logic [15:0] value,
	output logic req_valid,
	output mbio_pkg::mbio_req_s req
);
	// Between polls the bus inverts its word on every cycle, never a held value.
	always_ff @(posedge mclk) begin
		req_valid <= send;
		if (send) begin
			req <= {slave, func, 16'(reg_num - mbio_pkg::REG_NUM_BIAS), value};
		end else begin
			req <= ~req;
		end
	end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	logic [3:0] dial_tens = 4'h2;
	logic [3:0] dial_units = 4'h5;
	logic transparent_mode = 1'b0;
	logic [3:0] di = 4'h0;
	logic [3:0][15:0] ai = '0;
	logic send = 1'b0;
	logic [7:0] h_slave = 8'h00;
	logic [7:0] h_func = 8'h00;
	logic [16:0] h_reg = 17'h0;
	logic [15:0] h_val = 16'h0;
	logic req_valid, rsp_valid, fwd_valid, id_ok, ok_e;
	mbio_pkg::mbio_req_s req, fwd;
	mbio_pkg::mbio_rsp_s rsp;
	logic [7:0] own_id, id_e;
	logic [1:0] dout, sup, m_do, m_sp;
	logic [31:0] lfsr = 32'h874d;
	logic [31:0] r;
	logic [7:0] dials [8] = '{8'h00, 8'h01, 8'h10, 8'h60, 8'h61, 8'h99, 8'hc1, 8'h37};
	logic [7:0] fcs [6] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h10, 8'h83};
	int error_cnt = 0;
	int num_checks = 0;
	always #4 mclk = ~mclk;
	mbio_host HOST (.mclk(mclk), .send(send), .slave(h_slave), .func(h_func), .reg_num(h_reg),
		.value(h_val), .req_valid(req_valid), .req(req));
	mbio_regmap DUT (.mclk(mclk), .nrst(nrst), .ce(ce), .dial_tens(dial_tens),
		.dial_units(dial_units), .transparent_mode(transparent_mode), .discrete_input_n(di),
		.current_input_n(ai), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid),
		.rsp(rsp), .fwd_valid(fwd_valid), .fwd(fwd), .own_id(own_id), .id_ok(id_ok),
		.discrete_output_n(dout), .switched_supply_n(sup));
	task chk(input logic [47:0] seen, input logic [47:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task summarize();
		$display("checks=%0d mismatches=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	// Returns {exception, data} and tracks the outputs on an accepted write.
	function automatic logic [23:0] model(input logic [7:0] f, input logic [16:0] n,
		input logic [15:0] v);
		logic [16:0] o;
		logic wr;
		o = n - 17'h1f5;
		wr = (f == 8'h06);
		if (f != 8'h03 && !wr) return 24'h010000;
		if (n >= 17'h1 && n <= 17'h8) begin
			if (wr) return 24'h020000;
			return {8'h00, n < 17'h5 ? {15'h0, di[n - 17'h1]} : ai[n - 17'h5]};
		end
		if (o > 17'h5) return 24'h020000;
		if (wr && v > 16'h1 && o != 17'h2 && o != 17'h3) return 24'h030000;
		if (wr) begin
			if (o < 17'h2) m_do[o[0]] = v[0];
			if (o > 17'h3) m_sp[o[0]] = v[0];
			return {8'h00, v};
		end
		return {23'h0, o < 17'h2 ? m_do[o[0]] : (o > 17'h3 ? m_sp[o[0]] : 1'b0)};
	endfunction
	task op(input logic [7:0] s, input logic [7:0] f, input logic [16:0] n,
		input logic [15:0] v);
		logic [23:0] e;
		logic ans;
		logic fw;
		ans = ce && s == id_e && ok_e && !transparent_mode;
		fw = ce && !ans && !(s >= 8'h01 && s <= 8'h0a);
		@(posedge mclk);
		send <= 1'b1;
		h_slave <= s;
		h_func <= f;
		h_reg <= n;
		h_val <= v;
		@(posedge mclk);
		send <= 1'b0;
		@(posedge mclk);
		#1;
		chk({47'h0, rsp_valid}, {47'h0, ans});
		chk({47'h0, fwd_valid}, {47'h0, fw});
		if (fw) chk(fwd, {s, f, 16'(n - 17'h1), v});
		if (ans) begin
			e = model(f, n, v);
			chk({8'h0, rsp}, {8'h0, s, e[23:16] != 8'h0 ? f | 8'h80 : f, e});
		end
		chk({44'h0, dout, sup}, {44'h0, m_do, m_sp});
	endtask
	task dial(input logic [7:0] d);
		@(posedge mclk);
		dial_tens <= d[7:4];
		dial_units <= d[3:0];
		id_e = d[7:4] * 8'h0a + d[3:0];
		ok_e = d[7:4] <= 4'h9 && d[3:0] <= 4'h9 && id_e >= 8'h01 && id_e <= 8'h3c;
		repeat (5) @(posedge mclk);
		#1;
		if (d[7:4] <= 4'h9) chk({40'h0, own_id}, {40'h0, id_e});
		chk({47'h0, id_ok}, {47'h0, ok_e});
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		#1;
		m_do = 2'h0;
		m_sp = 2'h0;
		chk({44'h0, dout, sup}, 48'h0);
		@(posedge mclk);
		nrst <= 1'b1;
		// The last dial setting, 37, is a radio identity above the local range.
		for (int i = 0; i < 8; i++) dial(dials[i]);
		$display("identity test done");
		@(posedge mclk);
		ai <= {16'hffff, 16'h0000, 32'(rnd())};
		di <= 4'(rnd());
		repeat (4) @(posedge mclk);
		for (int n = 0; n < 10; n++) op(8'h25, 8'h03, 17'(n), 16'(rnd()));
		for (int n = 17'h1f4; n < 17'h1fc; n++) op(8'h25, 8'h03, 17'(n), 16'h0);
		$display("read test done");
		for (int k = 0; k < 3; k++) begin
			for (int n = 17'h1f5; n < 17'h1fb; n++) op(8'h25, 8'h06, 17'(n), 16'(2 - k));
		end
		op(8'h25, 8'h06, 17'h1, 16'h1);
		for (int i = 0; i < 6; i++) op(8'h25, fcs[i], 17'h1, 16'h1);
		$display("write test done");
		// Local slaves 01, 05, 07 and 0a stay on the wire; 0b to 1d and broadcast go out.
		foreach (dials[i]) op(8'h05 + dials[i] / 8'h08, 8'h03, 17'h1, 16'h1);
		op(8'h00, 8'h03, 17'h1, 16'h1);
		op(8'h01, 8'h03, 17'h1, 16'h1);
		op(8'h0a, 8'h03, 17'h1, 16'h1);
		$display("forward test done");
		@(posedge mclk);
		transparent_mode <= 1'b1;
		repeat (4) @(posedge mclk);
		op(8'h25, 8'h06, 17'h1f5, 16'h1);
		@(posedge mclk);
		transparent_mode <= 1'b0;
		repeat (4) @(posedge mclk);
		op(8'h25, 8'h03, 17'h1f5, 16'h0);
		$display("mode test done");
		// With the enable low a write to the own identity must leave every output alone.
		@(posedge mclk);
		ce <= 1'b0;
		repeat (2) @(posedge mclk);
		op(8'h25, 8'h06, 17'h1f6, 16'h1);
		@(posedge mclk);
		ce <= 1'b1;
		repeat (4) @(posedge mclk);
		op(8'h25, 8'h03, 17'h1f6, 16'h0);
		$display("enable test done");
		for (int i = 0; i < 300; i++) begin
			r = rnd();
			op(r[0] ? 8'h25 : r[15:8], r[1] ? 8'h03 : (r[2] ? 8'h06 : r[23:16]),
				{8'h0, r[3] ? 9'h1f0 : 9'h0} + 17'(r[7:4]), {14'h0, r[31:30]});
		end
		$display("random test done");
		summarize();
	end
	initial begin
		#100000;
		error_cnt++;
		summarize();
	end
endmodule
